// [inc/adc_seq_pkg.sv]
package adc_seq_pkg;
	localparam logic [3:0]  ADDR_CTRL2   = 4'h0;
	localparam logic [3:0]  ADDR_CTRL3   = 4'h1;
	localparam logic [3:0]  ADDR_STATUS  = 4'h2;
	localparam logic [3:0]  ADDR_MASK    = 4'h3;
	localparam logic [15:0] CTRL2_WMASK  = 16'hf43d;
	localparam logic [15:0] CTRL3_WMASK  = 16'hbf3f;
	localparam logic [15:0] CTRL2_RESET  = 16'h0000;
	localparam logic [15:0] CTRL3_RESET  = 16'h0000;
	localparam int          VREF_POS     = 13;
	localparam int          OFFSET_CAL_ENABLE_POS   = 12;
	localparam int          SCAN_POS     = 10;
	localparam int          SEQUENCES_PER_IRQ_POS     = 2;
	localparam int          ALTERNATE_MUX_SAMPLE_POS     = 0;
	localparam int          CLKSRC_POS   = 15;
	localparam int          AUTO_SAMPLE_TIME_POS     = 8;
	localparam int          CONV_CLOCK_DIVIDER_POS     = 0;
	localparam int          ST_SEQ       = 0;
	localparam int          ST_IRQ       = 1;
	localparam logic [3:0]  SEQUENCES_PER_IRQ_RESERVED = 4'hf;
	typedef enum logic [1:0] {
		REF_INT_INT,
		REF_EXT_INT,
		REF_INT_EXT,
		REF_EXT_EXT
	} ref_pair_t;
endpackage : adc_seq_pkg

// [logic/adc_divider.sv]
`timescale 1ns/1ns
// Conversion clock tick every (div + 1) cycles of the selected clock enable
module adc_divider (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Control
	input  wire logic       src_tick,
	input  wire logic [5:0] div,
	// Tick out
	output logic            tick
);
	logic [5:0] cnt;
	logic [5:0] next_cnt;
	logic       next_tick;

	always_comb begin
		next_cnt  = cnt;
		next_tick = 1'b0;
		if (src_tick) begin
			if (cnt >= div) begin
				next_cnt  = 6'h00;
				next_tick = 1'b1;
			end else begin
				next_cnt = cnt + 6'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt  <= 6'h00;
			tick <= 1'b0;
		end else begin
			cnt  <= next_cnt;
			tick <= next_tick;
		end
	end
endmodule : adc_divider

// [logic/adc_sequence_control.sv]
`timescale 1ns/1ns
module adc_sequence_control (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Register port
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	// Converter core
	input  wire logic        rc_clk_pin,
	input  wire logic        sample_done,
	input  wire logic        sequence_done,
	input  wire logic        sample_start,
	output logic             tad_tick,
	output logic      [4:0]  sample_tads,
	output logic             ref_pos_external,
	output logic             ref_neg_external,
	output logic             inputs_to_ground,
	output logic             switches_isolated,
	output logic             use_mux_b,
	output logic             scan_active,
	output logic      [3:0]  scan_index,
	// Interrupt
	output logic             irq
);
	logic [15:0] ctrl2;
	logic [15:0] ctrl3;
	logic [1:0]  status;
	logic [1:0]  mask;
	logic [3:0]  seq_count;
	logic        alt_phase;
	logic        rc_level;
	logic        rc_prev;
	logic        src_tick;
	logic [15:0] next_ctrl2;
	logic [15:0] next_ctrl3;
	logic [1:0]  next_status;
	logic [1:0]  next_mask;
	logic [3:0]  next_seq_count;
	logic        next_alt_phase;
	logic [3:0]  next_scan_index;
	logic [15:0] next_rdata;
	logic        seq_irq;
	logic [3:0]  sequences_per_irq;
	logic [2:0]  vref;
	logic        offset_cal_enable;

	assign sequences_per_irq   = ctrl2[adc_seq_pkg::SEQUENCES_PER_IRQ_POS +: 4];
	assign vref   = ctrl2[adc_seq_pkg::VREF_POS +: 3];
	assign offset_cal_enable = ctrl2[adc_seq_pkg::OFFSET_CAL_ENABLE_POS];

	////////////////////////////////////////////////////////////////
	// Conversion clock source and divider
	adc_sync u_rc_sync (
		.clk   (clk),
		.nrst  (nrst),
		.pin   (rc_clk_pin),
		.level (rc_level)
	);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rc_prev <= 1'b0;
		else
			rc_prev <= rc_level;
	end

	// RC edges only after synchronising; system path ticks every cycle
	assign src_tick = ctrl3[adc_seq_pkg::CLKSRC_POS] ? (rc_level & ~rc_prev) : 1'b1;

	adc_divider u_div (
		.clk      (clk),
		.nrst     (nrst),
		.src_tick (src_tick),
		.div      (ctrl3[adc_seq_pkg::CONV_CLOCK_DIVIDER_POS +: 6]),
		.tick     (tad_tick)
	);

	assign sample_tads = ctrl3[adc_seq_pkg::AUTO_SAMPLE_TIME_POS +: 5];

	////////////////////////////////////////////////////////////////
	// Reference and calibration routing
	always_comb begin
		ref_pos_external = 1'b0;
		ref_neg_external = 1'b0;
		if (!vref[2]) begin
			unique case (adc_seq_pkg::ref_pair_t'(vref[1:0]))
				adc_seq_pkg::REF_INT_INT: ;
				adc_seq_pkg::REF_EXT_INT: ref_pos_external = 1'b1;
				adc_seq_pkg::REF_INT_EXT: ref_neg_external = 1'b1;
				adc_seq_pkg::REF_EXT_EXT: begin
					ref_pos_external = 1'b1;
					ref_neg_external = 1'b1;
				end
			endcase
		end
	end

	// Calibration overrides mux and scan selection regardless of pin config; reference routing still follows vref
	assign inputs_to_ground  = offset_cal_enable;
	assign switches_isolated = offset_cal_enable;
	assign use_mux_b         = ~offset_cal_enable & ctrl2[adc_seq_pkg::ALTERNATE_MUX_SAMPLE_POS] & alt_phase;
	assign scan_active       = ~offset_cal_enable & ctrl2[adc_seq_pkg::SCAN_POS] & ~use_mux_b;

	////////////////////////////////////////////////////////////////
	// Sequencing state
	always_comb begin
		next_alt_phase  = alt_phase;
		next_scan_index = scan_index;
		next_seq_count  = seq_count;
		seq_irq         = 1'b0;
		// A new run opens on mux A, unless a sample end in the same cycle flips the old phase
		if (sample_start)
			next_alt_phase = 1'b0;
		if (sample_done && ctrl2[adc_seq_pkg::ALTERNATE_MUX_SAMPLE_POS])
			next_alt_phase = ~alt_phase;
		if (sample_done && scan_active)
			next_scan_index = scan_index + 4'h1;
		else if (!ctrl2[adc_seq_pkg::SCAN_POS])
			next_scan_index = 4'h0;
		if (sequence_done) begin
			if (seq_count >= sequences_per_irq) begin
				next_seq_count = 4'h0;
				seq_irq        = 1'b1;
			end else begin
				next_seq_count = seq_count + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Registers
	always_comb begin
		next_ctrl2  = ctrl2;
		next_ctrl3  = ctrl3;
		next_mask   = mask;
		next_status = status;
		if (wr) begin
			unique case (addr)
				adc_seq_pkg::ADDR_CTRL2:  next_ctrl2 = wdata & adc_seq_pkg::CTRL2_WMASK;
				adc_seq_pkg::ADDR_CTRL3:  next_ctrl3 = wdata & adc_seq_pkg::CTRL3_WMASK;
				adc_seq_pkg::ADDR_STATUS: next_status = status & ~wdata[1:0];
				adc_seq_pkg::ADDR_MASK:   next_mask = wdata[1:0];
				default: ;
			endcase
		end
		// Set wins over a same-cycle clear
		if (sequence_done)
			next_status[adc_seq_pkg::ST_SEQ] = 1'b1;
		if (seq_irq)
			next_status[adc_seq_pkg::ST_IRQ] = 1'b1;
		next_rdata = 16'h0000;
		if (rd) begin
			unique case (addr)
				adc_seq_pkg::ADDR_CTRL2:  next_rdata = ctrl2;
				adc_seq_pkg::ADDR_CTRL3:  next_rdata = ctrl3;
				adc_seq_pkg::ADDR_STATUS: next_rdata = {8'h00, seq_count, 2'h0, status};
				adc_seq_pkg::ADDR_MASK:   next_rdata = {14'h0000, mask};
				default: next_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl2      <= adc_seq_pkg::CTRL2_RESET;
			ctrl3      <= adc_seq_pkg::CTRL3_RESET;
			status     <= 2'h0;
			mask       <= 2'h0;
			seq_count  <= 4'h0;
			alt_phase  <= 1'b0;
			scan_index <= 4'h0;
			rdata      <= 16'h0000;
		end else begin
			ctrl2      <= next_ctrl2;
			ctrl3      <= next_ctrl3;
			status     <= next_status;
			mask       <= next_mask;
			seq_count  <= next_seq_count;
			alt_phase  <= next_alt_phase;
			scan_index <= next_scan_index;
			rdata      <= next_rdata;
		end
	end

	assign irq = |(status & mask);

	////////////////////////////////////////////////////////////////
	// Checks
	property p_cal_ground;
		@(posedge clk) disable iff (!nrst) offset_cal_enable |-> (inputs_to_ground && switches_isolated && !use_mux_b && !scan_active);
	endproperty
	a_cal_ground: assert property (p_cal_ground) else $error("calibration not isolating inputs");

	property p_cal_off;
		@(posedge clk) disable iff (!nrst) !offset_cal_enable |-> !inputs_to_ground;
	endproperty
	a_cal_off: assert property (p_cal_off) else $error("inputs grounded outside calibration");

	property p_ref_hi;
		@(posedge clk) disable iff (!nrst) vref[2] |-> (!ref_pos_external && !ref_neg_external);
	endproperty
	a_ref_hi: assert property (p_ref_hi) else $error("1xx code used external reference");

	property p_ref_ext;
		@(posedge clk) disable iff (!nrst) (vref == 3'h3) |-> (ref_pos_external && ref_neg_external);
	endproperty
	a_ref_ext: assert property (p_ref_ext) else $error("011 code not both external");

	property p_irq_each;
		@(posedge clk) disable iff (!nrst) (sequence_done && sequences_per_irq == 4'h0 && !(wr && addr == adc_seq_pkg::ADDR_CTRL2))
			|=> status[adc_seq_pkg::ST_IRQ];
	endproperty
	a_irq_each: assert property (p_irq_each) else $error("interrupt missing after sequence");

	property p_irq_count;
		@(posedge clk) disable iff (!nrst) seq_irq |-> (seq_count == sequences_per_irq);
	endproperty
	a_irq_count: assert property (p_irq_count) else $error("interrupt at wrong sequence count");

	property p_alt_off;
		@(posedge clk) disable iff (!nrst) !ctrl2[adc_seq_pkg::ALTERNATE_MUX_SAMPLE_POS] |-> !use_mux_b;
	endproperty
	a_alt_off: assert property (p_alt_off) else $error("mux B used without alternate mode");

	property p_alt_toggle;
		@(posedge clk) disable iff (!nrst) (sample_done && ctrl2[adc_seq_pkg::ALTERNATE_MUX_SAMPLE_POS] && !sample_start)
			|=> (alt_phase != $past(alt_phase));
	endproperty
	a_alt_toggle: assert property (p_alt_toggle) else $error("alternate phase did not flip");

	property p_unimpl;
		@(posedge clk) disable iff (!nrst) ((ctrl2 & ~adc_seq_pkg::CTRL2_WMASK) == 16'h0000)
			&& ((ctrl3 & ~adc_seq_pkg::CTRL3_WMASK) == 16'h0000);
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

	property p_sample_len;
		@(posedge clk) disable iff (!nrst) sample_tads == ctrl3[12:8];
	endproperty
	a_sample_len: assert property (p_sample_len) else $error("sample time mismatch");

	property p_scan;
		@(posedge clk) disable iff (!nrst) (sample_done && scan_active) |=> (scan_index == $past(scan_index) + 4'h1);
	endproperty
	a_scan: assert property (p_scan) else $error("scan index did not advance");

	// Tick is registered: judge by last cycle's setting, and skip the edge right after reset
	property p_sysclk;
		@(posedge clk) disable iff (!nrst)
			($past(nrst) && $past(!ctrl3[15] && ctrl3[5:0] == 6'h00)) |-> tad_tick;
	endproperty
	a_sysclk: assert property (p_sysclk) else $error("divide-by-one clock missing tick");

	property p_ref_pos_only;
		@(posedge clk) disable iff (!nrst) (vref == 3'h1) |-> (ref_pos_external && !ref_neg_external);
	endproperty
	a_ref_pos_only: assert property (p_ref_pos_only) else $error("001 code not positive external only");

	property p_ref_neg_only;
		@(posedge clk) disable iff (!nrst) (vref == 3'h2) |-> (!ref_pos_external && ref_neg_external);
	endproperty
	a_ref_neg_only: assert property (p_ref_neg_only) else $error("010 code not negative external only");

	property p_ref_int;
		@(posedge clk) disable iff (!nrst) (vref == 3'h0) |-> (!ref_pos_external && !ref_neg_external);
	endproperty
	a_ref_int: assert property (p_ref_int) else $error("000 code used external reference");

	property p_alt_start;
		@(posedge clk) disable iff (!nrst) (sample_start && !sample_done) |=> !alt_phase;
	endproperty
	a_alt_start: assert property (p_alt_start) else $error("run did not start on mux A");

	property p_scan_off;
		@(posedge clk) disable iff (!nrst) !ctrl2[adc_seq_pkg::SCAN_POS] |=> (scan_index == 4'h0);
	endproperty
	a_scan_off: assert property (p_scan_off) else $error("scan index not held at zero");

	property p_scan_mux_a;
		@(posedge clk) disable iff (!nrst) use_mux_b |-> !scan_active;
	endproperty
	a_scan_mux_a: assert property (p_scan_mux_a) else $error("scan ran on a mux B sample");

	property p_seq_status;
		@(posedge clk) disable iff (!nrst) sequence_done |=> status[adc_seq_pkg::ST_SEQ];
	endproperty
	a_seq_status: assert property (p_seq_status) else $error("sequence status bit not set");

	property p_irq_wrap;
		@(posedge clk) disable iff (!nrst) seq_irq |=> (seq_count == 4'h0);
	endproperty
	a_irq_wrap: assert property (p_irq_wrap) else $error("sequence count did not restart");

	property p_rc_gate;
		@(posedge clk) disable iff (!nrst) (ctrl3[adc_seq_pkg::CLKSRC_POS] && !src_tick) |=> !tad_tick;
	endproperty
	a_rc_gate: assert property (p_rc_gate) else $error("tick without an RC clock edge");

	property p_irq_set_wins;
		@(posedge clk) disable iff (!nrst) (seq_irq && wr && addr == adc_seq_pkg::ADDR_STATUS && wdata[adc_seq_pkg::ST_IRQ])
			|=> status[adc_seq_pkg::ST_IRQ];
	endproperty
	a_irq_set_wins: assert property (p_irq_set_wins) else $error("interrupt event lost to a clear");
endmodule : adc_sequence_control

// [logic/adc_sync.sv]
`timescale 1ns/1ns
// Three-stage pin synchroniser; a change counts when stages two and three agree
module adc_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Pin
	input  wire logic pin,
	// Clean level
	output logic      level
);
	logic [2:0] stage;
	logic       next_level;

	always_comb begin
		next_level = level;
		if (stage[1] == stage[2])
			next_level = stage[2];
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stage <= 3'h0;
			level <= 1'b0;
		end else begin
			stage <= {stage[1:0], pin};
			level <= next_level;
		end
	end
endmodule : adc_sync

// [verification/conv_core_model.sv]
`timescale 1ns/1ns
// Stand-in for the converter core: event pulses on request, free RC clock
module conv_core_model (
	// Clock
	input  wire logic clk,
	// Towards the block
	output logic      rc_clk_pin,
	output logic      sample_start,
	output logic      sample_done,
	output logic      sequence_done
);
	initial begin
		{sample_start, sample_done, sequence_done} = 3'h0;
		rc_clk_pin = 1'b0;
		// Odd offset keeps RC edges off the system clock edges
		#17;
		forever #300 rc_clk_pin = ~rc_clk_pin;
	end
	// Kind 0 run start, 1 sample end, 2 sequence end
	task pulse(input int kind);
		@(posedge clk);
		sample_start  <= (kind == 0);
		sample_done   <= (kind == 1);
		sequence_done <= (kind == 2);
		@(posedge clk);
		{sample_start, sample_done, sequence_done} <= 3'h0;
	endtask : pulse
endmodule : conv_core_model

// [verification/tb.sv]
`timescale 1ns/1ns
module tb;
	logic        clk, nrst, wr, rd, rd_q, rc_clk_pin, sample_start, sample_done, sequence_done;
	logic        tad_tick, ref_pos_external, ref_neg_external, inputs_to_ground;
	logic        switches_isolated, use_mux_b, scan_active, irq;
	logic [3:0]  addr, scan_index;
	logic [4:0]  sample_tads, auto_sample_time;
	logic [5:0]  dv;
	logic [15:0] wdata, rdata;
	logic [15:0] exp_q[$];
	int          fails, n_tests, seed, gap;

	adc_sequence_control dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .rc_clk_pin(rc_clk_pin), .sample_done(sample_done), .sequence_done(sequence_done),
		.sample_start(sample_start), .tad_tick(tad_tick), .sample_tads(sample_tads),
		.ref_pos_external(ref_pos_external), .ref_neg_external(ref_neg_external),
		.inputs_to_ground(inputs_to_ground), .switches_isolated(switches_isolated),
		.use_mux_b(use_mux_b), .scan_active(scan_active), .scan_index(scan_index), .irq(irq));
	conv_core_model core (.clk(clk), .rc_clk_pin(rc_clk_pin), .sample_start(sample_start),
		.sample_done(sample_done), .sequence_done(sequence_done));

	always #50 clk = ~clk;

	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	////////////////////////////////////////////////////////////////
	// Read data stand only in the cycle after the strobe
	always @(posedge clk) rd_q <= rd;
	always @(negedge clk) begin
		if (rd_q === 1'b1)
			chk(rdata, exp_q.pop_front());
	end

	task reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr
	task reg_rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask : reg_rd
	task settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	task do_reset;
		@(posedge clk);
		nrst <= 1'b0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
	endtask : do_reset
	// Cycles between two conversion clock ticks, bounded
	task tick_gap(output int g);
		g = 0;
		while (tad_tick !== 1'b1 && g < 2000) begin
			@(posedge clk);
			#1;
			g++;
		end
		g = 0;
		do begin
			@(posedge clk);
			#1;
			g++;
		end while (tad_tick !== 1'b1 && g < 2000);
	endtask : tick_gap
	task results;
		if (fails == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////
	initial begin
		#3000000;
		fails++;
		results();
	end

	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		{wr, rd} = 2'h0;
		seed = 76586;
		// Idle bus values are random: only the strobes give them meaning
		addr = 4'($random(seed));
		wdata = 16'($random(seed));
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		reg_rd(4'h0, adc_seq_pkg::CTRL2_RESET);
		reg_rd(4'h1, adc_seq_pkg::CTRL3_RESET);
		// Reserved bit one kept clear by software
		reg_wr(4'h0, 16'hfffd);
		reg_rd(4'h0, adc_seq_pkg::CTRL2_WMASK & 16'hfffd);
		reg_wr(4'h1, 16'hffff);
		reg_rd(4'h1, adc_seq_pkg::CTRL3_WMASK);
		reg_rd(4'h7, 16'h0000);
		for (int c = 0; c < 8; c++) begin
			reg_wr(4'h0, 16'(c) << 13);
			settle();
			chk(ref_pos_external, c == 1 || c == 3);
			chk(ref_neg_external, c == 2 || c == 3);
		end
		reg_wr(4'h0, 16'h1400);
		settle();
		chk({inputs_to_ground, switches_isolated, scan_active}, 3'h6);
		reg_wr(4'h0, 16'h0000);
		settle();
		chk({inputs_to_ground, switches_isolated, scan_active}, 3'h0);
		reg_wr(4'h0, 16'h0400);
		settle();
		chk(scan_active, 1'b1);
		core.pulse(1);
		core.pulse(1);
		settle();
		chk(scan_index, 4'h2);
		reg_wr(4'h0, 16'h0001);
		core.pulse(0);
		settle();
		chk(use_mux_b, 1'b0);
		for (int i = 0; i < 4; i++) begin
			core.pulse(1);
			settle();
			chk(use_mux_b, i % 2 == 0);
		end
		reg_wr(4'h0, 16'h0000);
		core.pulse(0);
		core.pulse(1);
		settle();
		chk(use_mux_b, 1'b0);
		for (int k = 0; k < 3; k++) begin
			auto_sample_time = 5'($random(seed));
			dv = 6'($random(seed) & 7);
			reg_wr(4'h1, {3'h0, auto_sample_time, 2'h0, dv});
			settle();
			chk(sample_tads, auto_sample_time);
			tick_gap(gap);
			chk(16'(gap), 16'(dv) + 16'h1);
			reg_wr(4'h1, {3'h4, auto_sample_time, 2'h0, dv});
			tick_gap(gap);
			tick_gap(gap);
			chk(16'(gap), (16'(dv) + 16'h1) * 16'h6);
		end
		for (int n = 0; n < 3; n++) begin
			do_reset();
			reg_wr(4'h3, 16'h0002);
			reg_wr(4'h0, 16'(n) << 2);
			for (int i = 0; i <= n; i++) begin
				chk(irq, 1'b0);
				core.pulse(2);
				settle();
			end
			chk(irq, 1'b1);
			reg_wr(4'h2, 16'h0002);
			settle();
			chk(irq, 1'b0);
		end
		// Sticky sequence bit, masking and clearing
		reg_wr(4'h3, 16'h0001);
		core.pulse(2);
		settle();
		chk(irq, 1'b1);
		reg_wr(4'h3, 16'h0000);
		settle();
		chk(irq, 1'b0);
		reg_wr(4'h2, 16'h0003);
		reg_wr(4'h3, 16'h0001);
		settle();
		chk(irq, 1'b0);
		results();
	end
endmodule : tb
